// [rtl/fsl_defs.vh]
// constants for the fieldbus slave state and indicator block
`ifndef FSL_DEFS_VH
`define FSL_DEFS_VH

// communication state codes, 4 bits wide
`define FSL_ST_W 4
`define FSL_ST_INIT 4'h1
`define FSL_ST_PREOP 4'h2
`define FSL_ST_BOOT 4'h3
`define FSL_ST_SAFEOP 4'h4
`define FSL_ST_OP 4'h8

// clock period and pattern base tick
`define FSL_CLK_PERIOD_NS 8
`define FSL_TICK_TIME_NS 50000000
`define FSL_TICK_CYCLES (`FSL_TICK_TIME_NS / `FSL_CLK_PERIOD_NS)

// pattern frame in ticks: one pattern period is 24 ticks (1.2 s)
`define FSL_PHASE_W 5
`define FSL_PHASE_LAST 5'h17
// blink: 4 ticks on, 4 ticks off
`define FSL_BLINK_BIT 2
// single flash: on while phase below 4
`define FSL_FLASH1_END 5'h04
// double flash: second flash from phase 8 to 11
`define FSL_FLASH2_START 5'h08
`define FSL_FLASH2_END 5'h0C

// indicator reset values
`define FSL_LED_OFF 1'h0

`endif

// [rtl/fsl_node.v]
// fieldbus slave communication state control, frame gating and LEDs
//
// Function
// RULE1: outgoing bytes replace passing frame bytes on the fly, no storing.
// RULE2: process data moves each frame; mailbox handled whenever it comes.
// RULE3: five states; only master requests change the state.
// RULE4: bootstrap accepts only file-transfer mailbox traffic, nothing else.
// RULE5: bootstrap reachable only from Init; otherwise an invalid transition.
// RULE6: Init allows neither mailbox nor process data.
// RULE7: Pre-Operational allows mailbox only.
// RULE8: Safe-Operational: mailbox, send process data, ignore received data.
// RULE9: Operational: mailbox and process data both ways.
// RULE10: four indicators: two link, one state (green) and one error (red).
// RULE11: link LED off no link, flicker with traffic, on when idle.
// RULE12: first link LED is input port, second is output port.
// RULE13: state LED off, blink, single flash, on for Init..Operational.
// RULE14: error LED off when clean, blinks after an invalid request.
// RULE15: error LED single flash on clock sync error.
// RULE16: error LED double flash on watchdog error.
// RULE17: error LED steady on during servo alarm.
// RULE18: all patterns come from one shared counter-based generator.
// RULE19: error LED shows most severe: alarm, watchdog, sync, invalid.
`timescale 1ns/1ps
`include "fsl_defs.vh"

module fsl_node #(
    parameter TICK_CYCLES = `FSL_TICK_CYCLES
) (
    // clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // master state requests
    input wire req_valid_in,
    input wire [`FSL_ST_W-1:0] req_state_in,
    input wire bad_setting_in,
    // passing frame stream
    input wire frm_valid_in,
    input wire [7:0] frm_data_in,
    input wire frm_tx_slot_in,
    input wire frm_rx_slot_in,
    input wire [7:0] tx_pdo_data_in,
    // mailbox requests
    input wire mbx_valid_in,
    input wire mbx_foe_in,
    // port pins from the physical layer
    input wire in_link_in,
    input wire in_act_in,
    input wire out_link_in,
    input wire out_act_in,
    // drive error conditions
    input wire sync_err_in,
    input wire wdog_err_in,
    input wire servo_alarm_in,
    // state report
    output reg [`FSL_ST_W-1:0] state_out,
    output reg req_done_out,
    output reg req_bad_out,
    // passing frame stream
    output reg frm_valid_out,
    output reg [7:0] frm_data_out,
    output reg tx_pdo_take_out,
    output reg rx_pdo_valid_out,
    output reg [7:0] rx_pdo_data_out,
    // mailbox answers
    output reg mbx_accept_out,
    output reg mbx_reject_out,
    // indicators
    output reg in_port_link_indicator_out,
    output reg out_port_link_indicator_out,
    output reg state_led_out,
    output reg error_led_out
);

    reg [`FSL_ST_W-1:0] state;
    reg [`FSL_ST_W-1:0] next_state;
    reg next_bad;
    reg bad_req;
    reg [2:0] in_link_s;
    reg [2:0] in_act_s;
    reg [2:0] out_link_s;
    reg [2:0] out_act_s;
    reg in_link;
    reg in_act;
    reg out_link;
    reg out_act;
    reg in_seen;
    reg out_seen;
    reg in_busy;
    reg out_busy;
    wire tick;
    wire flicker;
    wire blink;
    wire flash1;
    wire flash2;
    wire mbx_ok;
    wire tx_ok;
    wire rx_ok;

    // known state code check
    function is_state;
        input [`FSL_ST_W-1:0] s;
        begin
            is_state = (s == `FSL_ST_INIT) || (s == `FSL_ST_PREOP) ||
                (s == `FSL_ST_BOOT) || (s == `FSL_ST_SAFEOP) ||
                (s == `FSL_ST_OP);
        end
    endfunction

    // link indicator from link level and recent traffic
    function link_led;
        input link;
        input busy;
        input flick;
        begin
            if (!link)
                link_led = 1'b0;
            else if (busy)
                link_led = flick;
            else
                link_led = 1'b1;
        end
    endfunction

    // shared pattern source for every indicator
    fsl_pattern #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_pattern (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tick_out(tick),
        .flicker_out(flicker),
        .blink_out(blink),
        .flash1_out(flash1),
        .flash2_out(flash2)
    ); // [RULE18]

    // transition decode; upward moves go one step, downward moves are free
    always @* begin
        next_state = state;
        next_bad = 1'b0;
        if (req_valid_in && (req_state_in != state)) begin
            if (!is_state(req_state_in)) begin
                next_bad = 1'b1;
            end else if (req_state_in == `FSL_ST_BOOT) begin
                if (state == `FSL_ST_INIT)
                    next_state = `FSL_ST_BOOT;
                else
                    next_bad = 1'b1; // [RULE5]
            end else if (state == `FSL_ST_BOOT) begin
                // leaving bootstrap only back to Init
                if (req_state_in == `FSL_ST_INIT)
                    next_state = `FSL_ST_INIT;
                else
                    next_bad = 1'b1;
            end else begin
                case (req_state_in)
                    `FSL_ST_INIT: next_state = req_state_in;
                    `FSL_ST_PREOP: next_state = req_state_in;
                    `FSL_ST_SAFEOP: begin
                        if (state != `FSL_ST_INIT)
                            next_state = req_state_in;
                        else
                            next_bad = 1'b1;
                    end
                    `FSL_ST_OP: begin
                        if (state == `FSL_ST_SAFEOP)
                            next_state = req_state_in;
                        else
                            next_bad = 1'b1;
                    end
                    default: next_bad = 1'b1;
                endcase
            end
        end
    end

    // state register; moves only on a master request [RULE3]
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= `FSL_ST_INIT;
            state_out <= `FSL_ST_INIT;
            req_done_out <= 1'b0;
            req_bad_out <= 1'b0;
        end else begin
            state <= next_state; // [RULE3]
            state_out <= next_state;
            req_done_out <= req_valid_in && !next_bad;
            req_bad_out <= next_bad;
        end
    end

    // invalid request flag: a new fault wins over the clear by a good
    // request arriving in the same cycle
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            bad_req <= 1'b0;
        else if (next_bad || bad_setting_in)
            bad_req <= 1'b1; // [RULE14]
        else if (req_valid_in)
            bad_req <= 1'b0;
    end

    // what each state lets through
    assign mbx_ok = (state == `FSL_ST_PREOP) || (state == `FSL_ST_SAFEOP) ||
        (state == `FSL_ST_OP); // [RULE6] [RULE7] [RULE8] [RULE9]
    assign tx_ok = (state == `FSL_ST_SAFEOP) ||
        (state == `FSL_ST_OP); // [RULE7] [RULE8] [RULE9]
    assign rx_ok = (state == `FSL_ST_OP); // [RULE8] [RULE9]

    // mailbox answered in the cycle after it shows, whenever it shows
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mbx_accept_out <= 1'b0;
            mbx_reject_out <= 1'b0;
        end else if (mbx_valid_in) begin
            if (mbx_ok || ((state == `FSL_ST_BOOT) && mbx_foe_in)) begin
                mbx_accept_out <= 1'b1; // [RULE2] [RULE4]
                mbx_reject_out <= 1'b0;
            end else begin
                mbx_accept_out <= 1'b0;
                mbx_reject_out <= 1'b1; // [RULE4] [RULE6]
            end
        end else begin
            mbx_accept_out <= 1'b0;
            mbx_reject_out <= 1'b0;
        end
    end

    // one-byte pass-through: a slot byte is replaced as it goes by, so
    // latency stays one cycle whatever the frame length
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            frm_valid_out <= 1'b0;
            frm_data_out <= 8'h00;
            tx_pdo_take_out <= 1'b0;
            rx_pdo_valid_out <= 1'b0;
            rx_pdo_data_out <= 8'h00;
        end else begin
            frm_valid_out <= frm_valid_in;
            tx_pdo_take_out <= frm_valid_in && frm_tx_slot_in && tx_ok;
            if (frm_valid_in && frm_tx_slot_in && tx_ok)
                frm_data_out <= tx_pdo_data_in; // [RULE1] [RULE2]
            else
                frm_data_out <= frm_data_in;
            rx_pdo_valid_out <= frm_valid_in && frm_rx_slot_in && rx_ok;
            if (frm_valid_in && frm_rx_slot_in && rx_ok)
                rx_pdo_data_out <= frm_data_in; // [RULE9]
        end
    end

    // port pins: three-stage synchronisers; a level counts once the
    // second and third stages agree
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            in_link_s <= 3'h0;
            in_act_s <= 3'h0;
            out_link_s <= 3'h0;
            out_act_s <= 3'h0;
            in_link <= 1'b0;
            in_act <= 1'b0;
            out_link <= 1'b0;
            out_act <= 1'b0;
        end else begin
            in_link_s <= {in_link_s[1:0], in_link_in};
            in_act_s <= {in_act_s[1:0], in_act_in};
            out_link_s <= {out_link_s[1:0], out_link_in};
            out_act_s <= {out_act_s[1:0], out_act_in};
            if (in_link_s[1] == in_link_s[2])
                in_link <= in_link_s[2];
            if (in_act_s[1] == in_act_s[2])
                in_act <= in_act_s[2];
            if (out_link_s[1] == out_link_s[2])
                out_link <= out_link_s[2];
            if (out_act_s[1] == out_act_s[2])
                out_act <= out_act_s[2];
        end
    end

    // traffic seen within one tick keeps the port flickering a tick
    // longer; short bursts would otherwise be invisible
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            in_seen <= 1'b0;
            out_seen <= 1'b0;
            in_busy <= 1'b0;
            out_busy <= 1'b0;
        end else if (tick) begin
            in_busy <= in_seen || in_act;
            out_busy <= out_seen || out_act;
            in_seen <= 1'b0;
            out_seen <= 1'b0;
        end else begin
            in_seen <= in_seen || in_act;
            out_seen <= out_seen || out_act;
        end
    end

    // indicators, all registered
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            in_port_link_indicator_out <= `FSL_LED_OFF;
            out_port_link_indicator_out <= `FSL_LED_OFF;
            state_led_out <= `FSL_LED_OFF;
            error_led_out <= `FSL_LED_OFF;
        end else begin
            in_port_link_indicator_out <=
                link_led(in_link, in_busy, flicker); // [RULE11] [RULE12]
            out_port_link_indicator_out <=
                link_led(out_link, out_busy, flicker); // [RULE11] [RULE12]
            // bootstrap shows like Init: not a running state
            case (state)
                `FSL_ST_PREOP: state_led_out <= blink; // [RULE13]
                `FSL_ST_SAFEOP: state_led_out <= flash1; // [RULE13]
                `FSL_ST_OP: state_led_out <= 1'b1; // [RULE13]
                default: state_led_out <= `FSL_LED_OFF; // [RULE13]
            endcase
            // most severe error first [RULE19] [RULE10]
            if (servo_alarm_in)
                error_led_out <= 1'b1; // [RULE17]
            else if (wdog_err_in)
                error_led_out <= flash2; // [RULE16]
            else if (sync_err_in)
                error_led_out <= flash1; // [RULE15]
            else if (bad_req)
                error_led_out <= blink; // [RULE14]
            else
                error_led_out <= `FSL_LED_OFF; // [RULE14]
        end
    end

endmodule // fsl_node

// [rtl/fsl_pattern.v]
// shared pattern generator for flicker, blink, single and double flash
`timescale 1ns/1ps
`include "fsl_defs.vh"

module fsl_pattern #(
    parameter TICK_CYCLES = `FSL_TICK_CYCLES
) (
    // clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // patterns
    output reg tick_out,
    output reg flicker_out,
    output reg blink_out,
    output reg flash1_out,
    output reg flash2_out
);

    reg [31:0] pre;
    reg [`FSL_PHASE_W-1:0] phase;
    wire pre_done;

    assign pre_done = (pre == TICK_CYCLES - 1);

    // prescaler and phase counter; every pattern derives from one phase
    // so all indicators stay in step with each other
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre <= 32'h00000000;
            phase <= {`FSL_PHASE_W{1'b0}};
            tick_out <= 1'b0;
        end else begin
            tick_out <= pre_done;
            if (pre_done) begin
                pre <= 32'h00000000;
                if (phase == `FSL_PHASE_LAST)
                    phase <= {`FSL_PHASE_W{1'b0}};
                else
                    phase <= phase + 1'b1;
            end else begin
                pre <= pre + 32'h00000001;
            end
        end
    end

    // decode the phase into the four on/off patterns [RULE18]
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flicker_out <= 1'b0;
            blink_out <= 1'b0;
            flash1_out <= 1'b0;
            flash2_out <= 1'b0;
        end else begin
            flicker_out <= phase[0];
            blink_out <= ~phase[`FSL_BLINK_BIT];
            flash1_out <= (phase < `FSL_FLASH1_END);
            flash2_out <= (phase < `FSL_FLASH1_END) ||
                ((phase >= `FSL_FLASH2_START) &&
                 (phase < `FSL_FLASH2_END));
        end
    end

endmodule // fsl_pattern

// [test/fsl_master_model.sv]
// behavioural fieldbus master issuing state requests and bad settings
`timescale 1ns/1ps
`include "fsl_defs.vh"

module fsl_master_model (
    // clock
    input wire clk_in,
    // command lines toward the node
    output reg req_valid_out,
    output reg [`FSL_ST_W-1:0] req_state_out,
    output reg bad_setting_out
);
    // idle lines before the first command
    initial begin
        req_valid_out = 1'b0;
        req_state_out = `FSL_ST_INIT;
        bad_setting_out = 1'b0;
    end

    // one-cycle request; the code is scrambled once released
    task send_req(input [`FSL_ST_W-1:0] code);
        @(posedge clk_in);
        req_valid_out <= 1'b1;
        req_state_out <= code;
        @(posedge clk_in);
        req_valid_out <= 1'b0;
        req_state_out <= ~code;
    endtask

    // infeasible setting command, one cycle
    task send_bad;
        @(posedge clk_in);
        bad_setting_out <= 1'b1;
        @(posedge clk_in);
        bad_setting_out <= 1'b0;
    endtask
endmodule // fsl_master_model

// [test/fsl_node_asserts.sv]
// concurrent checks on the ports of the fieldbus slave node
`timescale 1ns/1ps
`include "fsl_defs.vh"

module fsl_node_asserts (
    // clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // watched inputs
    input wire req_valid_in,
    input wire [`FSL_ST_W-1:0] req_state_in,
    input wire frm_valid_in,
    input wire [7:0] frm_data_in,
    input wire frm_tx_slot_in,
    input wire frm_rx_slot_in,
    input wire [7:0] tx_pdo_data_in,
    input wire mbx_valid_in,
    input wire mbx_foe_in,
    input wire servo_alarm_in,
    // watched outputs
    input wire [`FSL_ST_W-1:0] state_out,
    input wire req_done_out,
    input wire req_bad_out,
    input wire frm_valid_out,
    input wire [7:0] frm_data_out,
    input wire tx_pdo_take_out,
    input wire rx_pdo_valid_out,
    input wire mbx_accept_out,
    input wire mbx_reject_out,
    input wire error_led_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // states in which outgoing process data may be inserted
    wire tx_open = state_out == `FSL_ST_SAFEOP || state_out == `FSL_ST_OP;
    wire tx_byte = frm_valid_in && frm_tx_slot_in;

    // a request for code c taken while in state f
    sequence s_req(logic [`FSL_ST_W-1:0] c, logic [`FSL_ST_W-1:0] f);
        req_valid_in && req_state_in == c && state_out == f;
    endsequence
    // a mailbox request taken while in state f
    sequence s_mbx(logic [`FSL_ST_W-1:0] f);
        mbx_valid_in && state_out == f;
    endsequence

    step_up_a: assert property (s_req(`FSL_ST_PREOP, `FSL_ST_INIT) |=>
        state_out == `FSL_ST_PREOP && req_done_out)
        else $error("init to preop not taken");
    state_hold_a: assert property (!req_valid_in |=> $stable(state_out))
        else $error("state moved without a request");
    boot_entry_a: assert property (req_valid_in &&
        req_state_in == `FSL_ST_BOOT && state_out != `FSL_ST_INIT &&
        state_out != `FSL_ST_BOOT |=>
        req_bad_out && !req_done_out && $stable(state_out))
        else $error("boot entered from outside init");
    init_mbx_a: assert property (s_mbx(`FSL_ST_INIT) |=>
        mbx_reject_out && !mbx_accept_out)
        else $error("mailbox served in init");
    boot_foe_a: assert property (s_mbx(`FSL_ST_BOOT) |=>
        mbx_accept_out == $past(mbx_foe_in) &&
        mbx_reject_out == !$past(mbx_foe_in))
        else $error("boot mailbox filter wrong");
    tx_insert_a: assert property (tx_byte && tx_open |=>
        frm_valid_out && tx_pdo_take_out &&
        frm_data_out == $past(tx_pdo_data_in))
        else $error("tx byte not inserted on the fly");
    tx_block_a: assert property (tx_byte && !tx_open |=>
        !tx_pdo_take_out && frm_data_out == $past(frm_data_in))
        else $error("tx byte inserted while closed");
    rx_block_a: assert property (frm_valid_in && frm_rx_slot_in &&
        state_out != `FSL_ST_OP |=> !rx_pdo_valid_out)
        else $error("rx data taken outside operational");
    alarm_on_a: assert property (servo_alarm_in [*5] |-> error_led_out)
        else $error("error led not on during alarm");
endmodule // fsl_node_asserts

// [test/fsl_node_tb_top.sv]
// self-checking bench for the fieldbus slave node
`timescale 1ns/1ps
`include "fsl_defs.vh"

module fsl_node_tb_top;
    // short tick keeps every pattern period at 192 cycles
    localparam TICKS = 8;
    localparam PER = 24 * TICKS;
    // request, expected state, expected refusal per step
    localparam [155:0] WALK = 156'h220440880381110411330231110511220821110;
    reg clk_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg frm_valid_in = 1'b0, frm_tx_slot_in = 1'b0, frm_rx_slot_in = 1'b0;
    reg [7:0] frm_data_in = 8'h00, tx_pdo_data_in = 8'h00;
    reg mbx_valid_in = 1'b0, mbx_foe_in = 1'b0;
    reg in_link_in = 1'b0, in_act_in = 1'b0;
    reg out_link_in = 1'b0, out_act_in = 1'b0;
    reg sync_err_in = 1'b0, wdog_err_in = 1'b0, servo_alarm_in = 1'b0;
    wire req_valid_in, bad_setting_in;
    wire [`FSL_ST_W-1:0] req_state_in, state_out;
    wire req_done_out, req_bad_out, frm_valid_out, tx_pdo_take_out;
    wire [7:0] frm_data_out, rx_pdo_data_out;
    wire rx_pdo_valid_out, mbx_accept_out, mbx_reject_out;
    wire in_port_link_indicator_out, out_port_link_indicator_out;
    wire state_led_out, error_led_out;
    integer fail_count = 0;
    integer cmp_count = 0;

    always #4 clk_in = ~clk_in;

    fsl_master_model i_mst (.clk_in(clk_in), .req_valid_out(req_valid_in),
        .req_state_out(req_state_in), .bad_setting_out(bad_setting_in));

    fsl_node #(.TICK_CYCLES(TICKS)) i_dut (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
        .req_state_in(req_state_in), .bad_setting_in(bad_setting_in),
        .frm_valid_in(frm_valid_in), .frm_data_in(frm_data_in),
        .frm_tx_slot_in(frm_tx_slot_in), .frm_rx_slot_in(frm_rx_slot_in),
        .tx_pdo_data_in(tx_pdo_data_in), .mbx_valid_in(mbx_valid_in),
        .mbx_foe_in(mbx_foe_in), .in_link_in(in_link_in),
        .in_act_in(in_act_in), .out_link_in(out_link_in),
        .out_act_in(out_act_in), .sync_err_in(sync_err_in),
        .wdog_err_in(wdog_err_in), .servo_alarm_in(servo_alarm_in),
        .state_out(state_out), .req_done_out(req_done_out),
        .req_bad_out(req_bad_out), .frm_valid_out(frm_valid_out),
        .frm_data_out(frm_data_out), .tx_pdo_take_out(tx_pdo_take_out),
        .rx_pdo_valid_out(rx_pdo_valid_out),
        .rx_pdo_data_out(rx_pdo_data_out), .mbx_accept_out(mbx_accept_out),
        .mbx_reject_out(mbx_reject_out),
        .in_port_link_indicator_out(in_port_link_indicator_out),
        .out_port_link_indicator_out(out_port_link_indicator_out),
        .state_led_out(state_led_out), .error_led_out(error_led_out));

    task chk(input string what, input [7:0] exp, input [7:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // mailbox request with one idle cycle around it
    task mbx_chk(input f, input a);
        @(posedge clk_in);
        mbx_valid_in <= 1'b1;
        mbx_foe_in <= f;
        @(posedge clk_in);
        mbx_valid_in <= 1'b0;
        #1;
        chk("mbx_accept", 8'(a), 8'(mbx_accept_out));
        chk("mbx_reject", 8'(!a), 8'(mbx_reject_out));
    endtask

    // a tx slot byte then an rx slot byte, back to back
    task frm_chk(input [`FSL_ST_W-1:0] st);
        reg tx;
        tx = st == `FSL_ST_SAFEOP || st == `FSL_ST_OP;
        @(posedge clk_in);
        frm_valid_in <= 1'b1;
        frm_tx_slot_in <= 1'b1;
        frm_data_in <= 8'hAA;
        tx_pdo_data_in <= 8'h55;
        @(posedge clk_in);
        frm_tx_slot_in <= 1'b0;
        frm_rx_slot_in <= 1'b1;
        frm_data_in <= 8'h3C;
        #1;
        chk("tx_byte", tx ? 8'h55 : 8'hAA, frm_data_out);
        chk("tx_take", 8'(tx), 8'(tx_pdo_take_out));
        chk("frm_valid", 8'h01, 8'(frm_valid_out));
        @(posedge clk_in);
        frm_valid_in <= 1'b0;
        frm_rx_slot_in <= 1'b0;
        #1;
        chk("rx_valid", 8'(st == `FSL_ST_OP), 8'(rx_pdo_valid_out));
        if (st == `FSL_ST_OP) chk("rx_byte", 8'h3C, rx_pdo_data_out);
    endtask

    // count lit cycles of each led over one full pattern period
    task led_chk(input [7:0] e_st, e_err, e_in, e_out);
        reg [7:0] n_st, n_err, n_in, n_out;
        integer k;
        n_st = 0;
        n_err = 0;
        n_in = 0;
        n_out = 0;
        repeat (24) @(posedge clk_in);
        for (k = 0; k < PER; k = k + 1) begin
            @(posedge clk_in);
            #1;
            n_st = n_st + 8'(state_led_out);
            n_err = n_err + 8'(error_led_out);
            n_in = n_in + 8'(in_port_link_indicator_out);
            n_out = n_out + 8'(out_port_link_indicator_out);
        end
        chk("state_led", e_st, n_st);
        chk("error_led", e_err, n_err);
        chk("in_link_led", e_in, n_in);
        chk("out_link_led", e_out, n_out);
    endtask

    // every transition kind, with mailbox and frame gating in each state
    task t_walk;
        reg [11:0] e;
        integer i;
        for (i = 0; i < 13; i = i + 1) begin
            e = WALK[155-12*i -: 12];
            i_mst.send_req(e[11:8]);
            #1;
            chk("state", 8'(e[7:4]), 8'(state_out));
            chk("req_bad", 8'(e[0]), 8'(req_bad_out));
            chk("req_done", 8'(!e[0]), 8'(req_done_out));
            mbx_chk(1'b0, e[7:4] != `FSL_ST_INIT &&
                e[7:4] != `FSL_ST_BOOT);
            mbx_chk(1'b1, e[7:4] != `FSL_ST_INIT);
            frm_chk(e[7:4]);
        end
        $display("walk done");
    endtask

    // state led in Init, PreOp, SafeOp and Op, then link leds per port
    task t_leds;
        i_mst.send_req(`FSL_ST_INIT);
        led_chk(0, 0, 0, 0);
        i_mst.send_req(`FSL_ST_PREOP);
        led_chk(PER / 2, 0, 0, 0);
        i_mst.send_req(`FSL_ST_SAFEOP);
        led_chk(4 * TICKS, 0, 0, 0);
        i_mst.send_req(`FSL_ST_OP);
        led_chk(PER, 0, 0, 0);
        @(posedge clk_in) in_link_in <= 1'b1;
        led_chk(PER, 0, PER, 0);
        @(posedge clk_in) in_act_in <= 1'b1;
        led_chk(PER, 0, PER / 2, 0);
        @(posedge clk_in) out_link_in <= 1'b1;
        led_chk(PER, 0, PER / 2, PER);
        $display("leds done");
    endtask

    // error sources stacked by rising severity, then cleared
    task t_errors;
        i_mst.send_req(`FSL_ST_BOOT);
        led_chk(PER, PER / 2, PER / 2, PER);
        @(posedge clk_in) sync_err_in <= 1'b1;
        led_chk(PER, 4 * TICKS, PER / 2, PER);
        @(posedge clk_in) wdog_err_in <= 1'b1;
        led_chk(PER, 8 * TICKS, PER / 2, PER);
        @(posedge clk_in) servo_alarm_in <= 1'b1;
        led_chk(PER, PER, PER / 2, PER);
        @(posedge clk_in) servo_alarm_in <= 1'b0;
        @(posedge clk_in) wdog_err_in <= 1'b0;
        @(posedge clk_in) sync_err_in <= 1'b0;
        i_mst.send_req(`FSL_ST_OP);
        led_chk(PER, 0, PER / 2, PER);
        i_mst.send_bad;
        led_chk(PER, PER / 2, PER / 2, PER);
        $display("errors done");
    endtask

    // reset in mid-run drops back to Init with dark leds, then restarts
    task t_reset;
        @(posedge clk_in) reset_n_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("rst_state", 8'(`FSL_ST_INIT), 8'(state_out));
        chk("rst_err_led", 8'h00, 8'(error_led_out));
        chk("rst_link_led", 8'h00, 8'(in_port_link_indicator_out));
        @(posedge clk_in) reset_n_in <= 1'b1;
        i_mst.send_req(`FSL_ST_PREOP);
        #1;
        chk("rst_step", 8'(`FSL_ST_PREOP), 8'(state_out));
        mbx_chk(1'b0, 1'b1);
        $display("reset done");
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        t_walk;
        t_leds;
        t_errors;
        t_reset;
        tally_and_finish;
    end

    // the tests need about 24 us; over twelve times that means a hang
    initial begin
        #300000;
        fail_count = fail_count + 1;
        tally_and_finish;
    end
endmodule // fsl_node_tb_top

bind fsl_node fsl_node_asserts i_chk (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
    .req_state_in(req_state_in), .frm_valid_in(frm_valid_in),
    .frm_data_in(frm_data_in), .frm_tx_slot_in(frm_tx_slot_in),
    .frm_rx_slot_in(frm_rx_slot_in), .tx_pdo_data_in(tx_pdo_data_in),
    .mbx_valid_in(mbx_valid_in), .mbx_foe_in(mbx_foe_in),
    .servo_alarm_in(servo_alarm_in), .state_out(state_out),
    .req_done_out(req_done_out), .req_bad_out(req_bad_out),
    .frm_valid_out(frm_valid_out), .frm_data_out(frm_data_out),
    .tx_pdo_take_out(tx_pdo_take_out), .rx_pdo_valid_out(rx_pdo_valid_out),
    .mbx_accept_out(mbx_accept_out), .mbx_reject_out(mbx_reject_out),
    .error_led_out(error_led_out));
